// file: common/pfw_pkg.sv
package pfw_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the apb bus
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DATA_LOW   = 12'h000;
  localparam logic [11:0] OFF_DATA_HIGH  = 12'h004;
  localparam logic [11:0] OFF_ADDR_LOW   = 12'h008;
  localparam logic [11:0] OFF_ADDR_HIGH  = 12'h00C;
  localparam logic [11:0] OFF_OP_CTRL    = 12'h010;
  localparam logic [11:0] OFF_UNLOCK_KEY = 12'h014;

  // ----------------------------------------------------------------
  // control register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RD   = 0;
  localparam int BIT_WR   = 1;
  localparam int BIT_PROGRAM_ERASE_ENABLE = 2;
  localparam int BIT_ERR  = 3;
  localparam int BIT_FREE = 4;
  localparam int BIT_LATCH_LOAD_ONLY = 5;
  localparam int BIT_CONFIG_SPACE_SELECT = 6;

  // ----------------------------------------------------------------
  // unlock key bytes and geometry
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'hAA;
  localparam logic [13:0] BLANK_WORD  = 14'h3FFF;
  localparam int          LATCH_COUNT = 32;
  localparam int          ARRAY_WORDS = 1024;   // model array depth, low address bits used
  localparam int          CFG_WORDS   = 16;

  // ----------------------------------------------------------------
  // configuration space map
  // ----------------------------------------------------------------
  localparam logic [14:0] CFG_UID_LO  = 15'h0000;
  localparam logic [14:0] CFG_UID_HI  = 15'h0003;
  localparam logic [14:0] CFG_RO_LO   = 15'h0005;
  localparam logic [14:0] CFG_RO_HI   = 15'h0008;
  localparam logic [13:0] CFG_FIXED_WORD = 14'h2A5C;  // arbitrary value: id and configuration words, read only

  // ----------------------------------------------------------------
  // self-timed operation length
  // ----------------------------------------------------------------
  localparam int  PROG_TIME_NS = 2000;
  localparam int  CLK_NS       = 10;
  localparam int  PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // flash command carried to the array model
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b001,
    CMD_ERASE = 3'b010,
    CMD_PROG  = 3'b100
  } pfw_cmd_t;

  typedef struct packed {
    pfw_cmd_t    cmd;
    logic        cfg;
    logic [14:0] addr;
  } pfw_req_t;

endpackage

// file: logic/pfw_array.sv
`timescale 1ns/1ns
// flash array model: main words, configuration words and the row latches
module pfw_array
  import pfw_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire pfw_pkg::pfw_req_t req,        // one-cycle command
  input  wire logic             latch_we,    // load one write latch
  input  wire logic [4:0]       latch_idx,   // latch index
  input  wire logic [13:0]      latch_data,  // latch value
  input  wire logic [14:0]      rd_addr,     // read address
  input  wire logic             rd_cfg,      // read from configuration space
  output      logic [13:0]      rd_data      // combinational read word
);
  logic [13:0] main_mem [ARRAY_WORDS];       // main program words
  logic [13:0] cfg_mem  [CFG_WORDS];         // user ids, ids, config words
  logic [13:0] latch_q  [LATCH_COUNT];       // row write latches
  logic [9:0]  row_base;                     // first word of addressed row

  assign row_base = {req.addr[9:5], 5'h00};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    if (rd_cfg) begin
      rd_data = cfg_mem[rd_addr[3:0]];
      // id and configuration words are fixed, only user ids are stored
      if (rd_addr >= CFG_RO_LO && rd_addr <= CFG_RO_HI) begin
        rd_data = CFG_FIXED_WORD;
      end
    end else begin
      rd_data = main_mem[rd_addr[9:0]];
    end
  end

  // ----------------------------------------------------------------
  // latches: loaded by software, blanked after every program or erase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LATCH_COUNT; i++) latch_q[i] <= BLANK_WORD;
    end else if (req.cmd != CMD_NONE) begin
      for (int i = 0; i < LATCH_COUNT; i++) latch_q[i] <= BLANK_WORD;  // RULE17
    end else if (latch_we) begin
      latch_q[latch_idx] <= latch_data;                                // RULE17
    end
  end

  // ----------------------------------------------------------------
  // array update: erase sets a row blank, program only clears bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (req.cmd == CMD_ERASE && !req.cfg) begin
      for (int i = 0; i < LATCH_COUNT; i++) main_mem[row_base + 10'(i)] <= BLANK_WORD;
    end else if (req.cmd == CMD_PROG && !req.cfg) begin
      for (int i = 0; i < LATCH_COUNT; i++) begin
        main_mem[row_base + 10'(i)] <= main_mem[row_base + 10'(i)] & latch_q[i];  // RULE18
      end
    end else if (req.cmd == CMD_ERASE && req.cfg) begin
      for (int i = 0; i < 4; i++) cfg_mem[i] <= BLANK_WORD;
    end else if (req.cmd == CMD_PROG && req.cfg) begin
      for (int i = 0; i < 4; i++) cfg_mem[i] <= cfg_mem[i] & latch_q[i];
    end
  end
endmodule

// file: logic/pfw_ctrl.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// flash self-write control with apb register access
// ----------------------------------------------------------------
// Notes on behaviour
// RULE1: space select picks configuration or main flash
// RULE2: config map: 0-3 rw, 5-8 read only
// RULE3: config read outside map clears data
// RULE4: read bit loads data, self clears
// RULE5: latch-only loads latch, else also programs
// RULE6: erase enable erases row, cleared after
// RULE7: latch-only ignored during erase
// RULE8: enable clear inhibits program and erase
// RULE9: write bit starts timed op, self clears
// RULE10: error flag set on every write-bit set
// RULE11: software writes 55h then AAh first
// RULE12: data high holds bits 13:8, 7:6 zero
// RULE13: address high bits 14:8, bit7 reads one
// RULE14: address, control reset zero; data kept; the error flag has no reset
// RULE15: software read-modify-erase-reload for partial rows
// RULE16: software may verify row after write
// RULE17: low five bits pick latch, blank after
// RULE18: program never erases the row itself
// RULE19: broken key loads and programs nothing
// RULE20: stall processor during timed operation; code stalls only for program or erase, not latch-only
// RULE21: config writes outside user ids ignored
// RULE22: no enable or no key: no cycle
module pfw_ctrl
  import pfw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        cpu_stall   // holds the processor during a timed program or erase, not a latch-only load
);
  import pfw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } pfw_state_t;

  pfw_state_t  state_q;                  // sequencer state
  logic [7:0]  dat_lo_q;                 // data low byte
  logic [5:0]  dat_hi_q;                 // data high bits 13:8
  logic [7:0]  adr_lo_q;                 // address low byte
  logic [6:0]  adr_hi_q;                 // address high bits 14:8
  logic        config_space_select_q;                   // space select
  logic        latch_load_only_q;                   // latch load only
  logic        free_q;                   // erase enable
  logic        err_q;                    // sequence error flag
  logic        program_erase_enable_q;                   // program/erase enable
  logic        wr_q;                     // write control
  logic        rd_q;                     // read control
  logic [1:0]  key_q;                    // 0 none, 1 first byte, 2 unlocked
  logic [15:0] cnt_q;                    // self-timed countdown
  logic        erase_q;                  // current operation is an erase
  pfw_req_t    req_q;                    // command to array
  logic        latch_we_q;               // latch load strobe
  logic [13:0] rd_word;                  // array read word
  logic [14:0] word_addr;                // full word address

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic cfg_readable(input logic [14:0] a);
    cfg_readable = (a <= CFG_UID_HI) || (a >= CFG_RO_LO && a <= CFG_RO_HI);   // RULE2
  endfunction

  function automatic logic cfg_writable(input logic [14:0] a);
    cfg_writable = (a <= CFG_UID_HI);                                          // RULE2
  endfunction

  assign word_addr = {adr_hi_q, adr_lo_q};

  // ----------------------------------------------------------------
  // apb strobes
  // ----------------------------------------------------------------
  logic acc;        // access phase
  logic wr_acc;     // write taken this edge
  logic wr_set;     // software sets write bit
  logic rd_set;     // software sets read bit
  logic go;         // write command accepted
  logic mapped;     // address hits a register

  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign mapped = (paddr == OFF_DATA_LOW) || (paddr == OFF_DATA_HIGH) || (paddr == OFF_ADDR_LOW) ||
                  (paddr == OFF_ADDR_HIGH) || (paddr == OFF_OP_CTRL) || (paddr == OFF_UNLOCK_KEY);
  assign wr_set = wr_acc && (paddr == OFF_OP_CTRL) && pwdata[BIT_WR] && !wr_q;        // RULE9
  assign rd_set = wr_acc && (paddr == OFF_OP_CTRL) && pwdata[BIT_RD] && !wr_set;
  // a command runs only when enabled, unlocked and aimed at writable space
  assign go     = wr_set && program_erase_enable_q && (key_q == 2'd2) &&
                  (!config_space_select_q || cfg_writable(word_addr));                             // RULE8 RULE22 RULE21

  // ----------------------------------------------------------------
  // apb answer: single-cycle access phase, unmapped reports error
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          OFF_DATA_LOW:  prdata <= {24'h000000, dat_lo_q};
          OFF_DATA_HIGH: prdata <= {24'h000000, 2'b00, dat_hi_q};                   // RULE12
          OFF_ADDR_LOW:  prdata <= {24'h000000, adr_lo_q};
          OFF_ADDR_HIGH: prdata <= {24'h000000, 1'b1, adr_hi_q};                    // RULE13
          OFF_OP_CTRL:   prdata <= {24'h000000, 1'b1, config_space_select_q, latch_load_only_q, free_q,
                                    err_q, program_erase_enable_q, wr_q, rd_q};                     // RULE13
          default:       prdata <= 32'h0000_0000;   // key is write only
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // address and control bits, reset to zero
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adr_lo_q <= 8'h00;                                                            // RULE14
      adr_hi_q <= 7'h00;
      config_space_select_q   <= 1'b0;
      latch_load_only_q   <= 1'b0;
      program_erase_enable_q   <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == OFF_ADDR_LOW) adr_lo_q <= pwdata[7:0];
      if (paddr == OFF_ADDR_HIGH) adr_hi_q <= pwdata[6:0];
      if (paddr == OFF_OP_CTRL) begin
        config_space_select_q <= pwdata[BIT_CONFIG_SPACE_SELECT];                                                 // RULE1
        latch_load_only_q <= pwdata[BIT_LATCH_LOAD_ONLY];
        program_erase_enable_q <= pwdata[BIT_PROGRAM_ERASE_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // erase enable: cleared by hardware when the erase ends
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_q <= 1'b0;
    end else if (state_q == ST_BUSY && cnt_q == 16'h0000 && erase_q) begin
      free_q <= 1'b0;                                                               // RULE6
    end else if (wr_acc && paddr == OFF_OP_CTRL) begin
      free_q <= pwdata[BIT_FREE];
    end
  end

  // ----------------------------------------------------------------
  // error flag: no reset value, set on every write-bit set attempt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (wr_acc && paddr == OFF_OP_CTRL && pwdata[BIT_WR]) begin
      err_q <= 1'b1;                                                                // RULE10
    end else if (wr_acc && paddr == OFF_OP_CTRL) begin
      err_q <= pwdata[BIT_ERR];
    end
  end

  // ----------------------------------------------------------------
  // unlock key: 55h then aah, any other write in between breaks it
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= 2'd0;
    end else if (wr_acc && paddr == OFF_UNLOCK_KEY) begin
      if (pwdata[7:0] == KEY_FIRST) begin
        key_q <= 2'd1;
      end else if (pwdata[7:0] == KEY_SECOND && key_q == 2'd1) begin
        key_q <= 2'd2;                                                              // RULE11
      end else begin
        key_q <= 2'd0;                                                              // RULE19
      end
    end else if (wr_acc) begin
      key_q <= 2'd0;                                                                // RULE19
    end
  end

  // ----------------------------------------------------------------
  // sequencer: latch load, then self-timed wait, then program or erase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      wr_q       <= 1'b0;
      cnt_q      <= 16'h0000;
      erase_q    <= 1'b0;
      latch_we_q <= 1'b0;
      cpu_stall  <= 1'b0;
      req_q      <= '{cmd: CMD_NONE, cfg: 1'b0, addr: 15'h0000};
    end else begin
      latch_we_q <= 1'b0;
      req_q.cmd  <= CMD_NONE;
      unique case (state_q)
        ST_IDLE: begin
          if (go) begin
            wr_q      <= 1'b1;                                                      // RULE9
            erase_q   <= free_q;
            cnt_q     <= 16'(PROG_CYCLES);
            state_q   <= ST_BUSY;
            cpu_stall <= free_q || !latch_load_only_q;                                         // RULE20
            req_q.cfg  <= config_space_select_q;
            req_q.addr <= word_addr;
            latch_we_q <= !free_q;                                                  // RULE7
          end
        end
        ST_BUSY: begin
          if (cnt_q == 16'h0000) begin
            wr_q      <= 1'b0;                                                      // RULE9
            cpu_stall <= 1'b0;
            state_q   <= ST_IDLE;
            if (erase_q) begin
              req_q.cmd <= CMD_ERASE;                                               // RULE6 RULE7
            end else if (!latch_load_only_q) begin
              req_q.cmd <= CMD_PROG;                                                // RULE5
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read control (reset to zero) and data registers (no reset, kept across resets)
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_set;                                                               // RULE4
    end
  end

  always_ff @(posedge pclk) begin
    if (rd_q) begin
      if (config_space_select_q && !cfg_readable(word_addr)) begin
        dat_lo_q <= 8'h00;                                                          // RULE3
        dat_hi_q <= 6'h00;
      end else begin
        dat_lo_q <= rd_word[7:0];                                                   // RULE4 RULE1
        dat_hi_q <= rd_word[13:8];
      end
    end else if (wr_acc && paddr == OFF_DATA_LOW) begin
      dat_lo_q <= pwdata[7:0];
    end else if (wr_acc && paddr == OFF_DATA_HIGH) begin
      dat_hi_q <= pwdata[5:0];                                                      // RULE12
    end
  end

  // ----------------------------------------------------------------
  // flash array with row latches
  // ----------------------------------------------------------------
  pfw_array u_array (
    .pclk       (pclk),
    .presetn    (presetn),
    .req        (req_q),
    .latch_we   (latch_we_q),
    .latch_idx  (req_q.addr[4:0]),                                                  // RULE17
    .latch_data ({dat_hi_q, dat_lo_q}),
    .rd_addr    (word_addr),
    .rd_cfg     (config_space_select_q),
    .rd_data    (rd_word)
  );
endmodule

// file: test/pfw_ctrl_asserts.sv
`timescale 1ns/1ns
// ------------------
// port checks
// ------------------
module pfw_ctrl_asserts
  import pfw_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_stall
);
  logic [1:0] key_q;       // unlock bytes seen in order
  logic       armed_q;     // last control write may start a cycle
  logic [8:0] stall_cnt_q; // length of the current stall
  logic       wr_xfer;     // completed write transfer
  logic       rd_xfer;     // completed read transfer

  assign wr_xfer = psel && penable && pready && pwrite;
  assign rd_xfer = psel && penable && pready && !pwrite;

  // any other write breaks the key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= 2'd0;
    end else if (wr_xfer) begin
      if (paddr == OFF_UNLOCK_KEY && pwdata[7:0] == KEY_FIRST) begin
        key_q <= 2'd1;
      end else if (paddr == OFF_UNLOCK_KEY && pwdata[7:0] == KEY_SECOND && key_q == 2'd1) begin
        key_q <= 2'd2;
      end else begin
        key_q <= 2'd0;
      end
    end
  end

  // control write with key, enable and write bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (wr_xfer && paddr == OFF_OP_CTRL) begin
      armed_q <= key_q == 2'd2 && pwdata[BIT_PROGRAM_ERASE_ENABLE] && pwdata[BIT_WR];
    end
  end

  // count stall cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_q <= 9'd0;
    end else if (cpu_stall) begin
      stall_cnt_q <= stall_cnt_q + 9'd1;
    end else begin
      stall_cnt_q <= 9'd0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");

  property p_ready_pulse;
    pready |-> psel && penable ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready outside one access cycle");

  property p_err_map;
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFF_UNLOCK_KEY);
  endproperty
  a_err_map: assert property (p_err_map) else $error("slave error against address map");

  property p_err_zero;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");

  property p_key_zero;
    rd_xfer && paddr == OFF_UNLOCK_KEY |-> prdata == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key register readable");

  property p_data_high;
    rd_xfer && paddr == OFF_DATA_HIGH |-> prdata[7:6] == 2'b00;
  endproperty
  a_data_high: assert property (p_data_high) else $error("data high top bits set");

  property p_top_bit;
    rd_xfer && (paddr == OFF_ADDR_HIGH || paddr == OFF_OP_CTRL) |-> prdata[7];
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("top bit not one");

  property p_stall_key;
    $rose(cpu_stall) |-> armed_q;
  endproperty
  a_stall_key: assert property (p_stall_key) else $error("stall without unlock");

  property p_stall_len;
    cpu_stall |-> stall_cnt_q <= PROG_CYCLES + 1;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall too long");

  c_stall: cover property ($rose(cpu_stall));
  c_slverr: cover property (pslverr);
  c_armed: cover property (key_q == 2'd2 ##1 armed_q);
endmodule

bind pfw_ctrl pfw_ctrl_asserts i_chk (
  .pclk     (pclk),
  .presetn  (presetn),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .paddr    (paddr),
  .pwdata   (pwdata),
  .prdata   (prdata),
  .pready   (pready),
  .pslverr  (pslverr),
  .cpu_stall(cpu_stall)
);

// file: test/pfw_cpu_model.sv
`timescale 1ns/1ns
// ------------------
// software side apb master
// ------------------
module pfw_cpu_model
  import pfw_pkg::*;
(
  input  wire logic        pclk,
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [11:0] paddr,
  output      logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // idle bus at start
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // one transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata; // released data no longer valid
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask

  // both key bytes, in order
  task automatic unlock();
    wr(OFF_UNLOCK_KEY, KEY_FIRST);
    wr(OFF_UNLOCK_KEY, KEY_SECOND);
  endtask
endmodule

// file: test/pfw_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module pfw_ctrl_tb;
  import pfw_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        cpu_stall;
  logic        stall_seen; // stall observed since last clear
  logic [7:0]  q;
  logic [13:0] w;
  logic [13:0] v;
  int          err_count;
  int          check_count;

  pfw_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .cpu_stall(cpu_stall));
  pfw_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (cpu_stall === 1'b1) stall_seen <= 1'b1;

  task automatic chk_rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    i_cpu.rd(a, q);
    `CHK(q & m, e)
  endtask

  // read one word through the read bit
  task automatic chk_w(input logic [14:0] a, input logic cfg, input logic [13:0] e);
    logic [7:0] lo;
    i_cpu.wr(OFF_ADDR_LOW, a[7:0]);
    i_cpu.wr(OFF_ADDR_HIGH, {1'b0, a[14:8]});
    i_cpu.wr(OFF_OP_CTRL, {1'b0, cfg, 6'b000001});
    i_cpu.rd(OFF_OP_CTRL, lo);
    `CHK(lo[BIT_RD], 1'b0)
    i_cpu.rd(OFF_DATA_LOW, lo);
    i_cpu.rd(OFF_DATA_HIGH, q);
    w = {q[5:0], lo};
    `CHK(w, e)
  endtask

  task automatic set_word(input logic [14:0] a, input logic [13:0] d);
    i_cpu.wr(OFF_ADDR_LOW, a[7:0]);
    i_cpu.wr(OFF_ADDR_HIGH, {1'b0, a[14:8]});
    i_cpu.wr(OFF_DATA_LOW, d[7:0]);
    i_cpu.wr(OFF_DATA_HIGH, {2'b00, d[13:8]});
  endtask

  // mode and enable first, then the unlocked command, then poll until the write bit drops
  task automatic cmd(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c);
    int n;
    i_cpu.wr(OFF_OP_CTRL, c & 8'hFD);
    set_word(a, d);
    stall_seen = 1'b0;
    i_cpu.unlock();
    i_cpu.wr(OFF_OP_CTRL, c);
    n = 0;
    q = 8'h02;
    while (q[BIT_WR] !== 1'b0 && n < 400) begin
      i_cpu.rd(OFF_OP_CTRL, q);
      n++;
    end
    `CHK(q[BIT_WR], 1'b0)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #300000;
    err_count++;
    results();
  end

  initial begin
    err_count = 0;
    check_count = 0;
    stall_seen = 1'b0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(OFF_ADDR_LOW, 8'hFF, 8'h00);
    chk_rd(OFF_ADDR_HIGH, 8'hFF, 8'h80);
    chk_rd(OFF_OP_CTRL, 8'hF7, 8'h80);
    i_cpu.wr(OFF_DATA_HIGH, 8'hFF);
    chk_rd(OFF_DATA_HIGH, 8'hFF, 8'h3F);
    i_cpu.wr(12'h018, 8'h5A);
    chk_rd(12'h018, 8'hFF, 8'h00);
    chk_rd(OFF_UNLOCK_KEY, 8'hFF, 8'h00);
    $display("test registers done");
    cmd(15'h0040, 14'h0000, 8'h36);
    `CHK(stall_seen, 1'b1)
    chk_rd(OFF_OP_CTRL, 8'h3E, 8'h2C);
    chk_w(15'h0040, 1'b0, BLANK_WORD);
    cmd(15'h0041, 14'h1234, 8'h26);
    `CHK(stall_seen, 1'b0)
    chk_w(15'h0041, 1'b0, BLANK_WORD);
    cmd(15'h0042, 14'h0ABC, 8'h06);
    `CHK(stall_seen, 1'b1)
    chk_w(15'h0041, 1'b0, 14'h1234);
    chk_w(15'h0042, 1'b0, 14'h0ABC);
    chk_w(15'h0043, 1'b0, BLANK_WORD);
    $display("test erase and program done");
    set_word(15'h0044, 14'h0111);
    stall_seen = 1'b0;
    i_cpu.wr(OFF_OP_CTRL, 8'h04);
    i_cpu.wr(OFF_UNLOCK_KEY, KEY_FIRST);
    i_cpu.wr(OFF_DATA_LOW, 8'h11);
    i_cpu.wr(OFF_UNLOCK_KEY, KEY_SECOND);
    i_cpu.wr(OFF_OP_CTRL, 8'h06);
    repeat (PROG_CYCLES + 10) @(posedge pclk);
    `CHK(stall_seen, 1'b0)
    chk_rd(OFF_OP_CTRL, 8'h0A, 8'h08);
    chk_w(15'h0044, 1'b0, BLANK_WORD);
    cmd(15'h0045, 14'h0222, 8'h02);
    `CHK(stall_seen, 1'b0)
    chk_w(15'h0045, 1'b0, BLANK_WORD);
    $display("test refused commands done");
    chk_w(15'h0005, 1'b1, CFG_FIXED_WORD);
    v = w;
    cmd(15'h0000, 14'h0000, 8'h56);
    cmd(15'h0001, 14'h0155, 8'h46);
    chk_w(15'h0001, 1'b1, 14'h0155);
    chk_w(15'h0042, 1'b0, 14'h0ABC);
    cmd(15'h0005, 14'h0000, 8'h46);
    `CHK(stall_seen, 1'b0)
    chk_w(15'h0005, 1'b1, v);
    i_cpu.wr(OFF_DATA_LOW, 8'hFF);
    chk_w(15'h0004, 1'b1, 14'h0000);
    chk_w(15'h0009, 1'b1, 14'h0000);
    $display("test configuration space done");
    results();
  end
endmodule
